// ==== design/stream_descriptor_parser.sv ====
`timescale 1ns/1ns
`default_nettype none

// Operation
// (R01) Kind byte, then length byte, then body
// (R02) Length counts body bytes; finds descriptor end
// (R03) Classify kind: reserved, video, audio, hierarchy, standard, private
// (R04) Flag kind permitted in current multiplex type
// (R05) Input selects transport or program multiplex
// (R06) Video mixed rates flag, first body bit
// (R07) Rate index plus admitted lower rates
// (R08) Legacy video only flag
// (R09) Bounded parameters flag; flag violations
// (R10) Stills only flag
// (R11) Legacy set: class, sampling, extension fields
// (R12) Expose rate extension flag
// (R13) Audio fields in order
// (R14) Unindexed bitrate flag
// (R15) Audio version and layer passed unchanged
// (R16) Rate varies flag
// (R17) Hierarchy fields extracted in order
// (R18) Decode scalability kind incl. base layer
// (R19) Prerequisite index undefined for base layer
// (R20) Skip unparsed descriptors by length
module stream_descriptor_parser (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Descriptor byte stream
	input wire logic in_valid,
	input wire logic [7:0] in_byte,
	input wire logic in_sync,
	input wire logic prog_mux,
	// Descriptor summary
	output logic desc_done_ff,
	output logic [7:0] desc_kind_ff,
	output var stream_desc_pkg::kind_class_t desc_class_ff,
	output logic desc_allowed_ff,
	output logic desc_short_ff,
	// Video fields
	output logic video_valid_ff,
	output logic vid_mixed_ff,
	output logic [3:0] vid_rate_ff,
	output logic [7:0] vid_rate_admit_ff,
	output logic legacy_video_only_ff,
	output logic vid_bounded_ff,
	output logic vid_stills_ff,
	output logic [7:0] vid_cap_class_ff,
	output logic [1:0] vid_sampling_ff,
	output logic vid_rate_ext_ff,
	output logic bounded_err_ff,
	// Audio fields
	output logic audio_valid_ff,
	output logic aud_unindexed_ff,
	output logic audio_version_bit_ff,
	output logic [1:0] aud_layer_ff,
	output logic aud_varies_ff,
	// Hierarchy fields
	output logic hier_valid_ff,
	output logic [3:0] hier_kind_ff,
	output logic hier_base_ff,
	output logic hier_kind_res_ff,
	output logic [5:0] hier_own_ff,
	output logic [5:0] hier_prereq_ff,
	output logic hier_prereq_ok_ff,
	output logic [5:0] hier_channel_ff
);

	typedef enum logic [1:0] {
		ST_KIND,
		ST_LEN,
		ST_BODY
	} parse_state_t;

	parse_state_t state_ff;
	logic [7:0] left_ff;
	logic [7:0] idx_ff;
	logic [7:0] len_ff;
	stream_desc_pkg::kind_class_t dec_class;
	logic dec_allowed;
	logic take_kind;
	logic take_len;
	logic take_body;
	logic desc_end;
	logic [7:0] end_len;
	logic legacy_now;
	logic bounded_now;
	logic [7:0] need_cnt;
	logic is_video;
	logic is_audio;
	logic is_hier;

	// ==========================================
	// Kind decode
	// ==========================================
	desc_kind_decode u_kind (
		.kind(in_byte),
		.prog_mux(prog_mux),
		.kind_class(dec_class),
		.allowed(dec_allowed)
	);

	// ==========================================
	// Byte sequencing
	// ==========================================
	assign take_kind = in_valid && !in_sync && state_ff == ST_KIND;
	assign take_len = in_valid && !in_sync && state_ff == ST_LEN;
	assign take_body = in_valid && !in_sync && state_ff == ST_BODY;
	// Empty body or last counted byte closes the descriptor
	assign desc_end = (take_len && in_byte == 8'h00) || (take_body && left_ff == 8'h01); // R02
	assign end_len = take_len ? in_byte : len_ff;
	assign is_video = desc_class_ff == stream_desc_pkg::CL_VIDEO;
	assign is_audio = desc_class_ff == stream_desc_pkg::CL_AUDIO;
	assign is_hier = desc_class_ff == stream_desc_pkg::CL_HIER;

	// State advance; sync restarts at a kind byte
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_ff <= ST_KIND;
		end else if (in_sync) begin
			state_ff <= ST_KIND;
		end else if (in_valid) begin
			case (state_ff)
				ST_KIND: state_ff <= ST_LEN; // R01
				ST_LEN: state_ff <= (in_byte == 8'h00) ? ST_KIND : ST_BODY; // R02
				ST_BODY: state_ff <= (left_ff == 8'h01) ? ST_KIND : ST_BODY; // R20
				default: state_ff <= ST_KIND;
			endcase
		end
	end

	// Remaining and position counters
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			left_ff <= 8'h00;
			idx_ff <= 8'h00;
			len_ff <= 8'h00;
		end else if (take_len) begin
			left_ff <= in_byte; // R02
			len_ff <= in_byte;
			idx_ff <= 8'h00;
		end else if (take_body) begin
			left_ff <= left_ff - 8'h01; // R20
			idx_ff <= idx_ff + 8'h01;
		end
	end

	// Kind, class and permission latch
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			desc_kind_ff <= 8'h00;
			desc_class_ff <= stream_desc_pkg::CL_RESERVED;
			desc_allowed_ff <= 1'b0;
		end else if (take_kind) begin
			desc_kind_ff <= in_byte; // R01
			desc_class_ff <= dec_class; // R03
			desc_allowed_ff <= dec_allowed; // R04
		end
	end

	// ==========================================
	// Video fields
	// ==========================================
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			vid_mixed_ff <= 1'b0;
			vid_rate_ff <= 4'h0;
			vid_rate_admit_ff <= 8'h00;
			legacy_video_only_ff <= 1'b0;
			vid_bounded_ff <= 1'b0;
			vid_stills_ff <= 1'b0;
		end else if (take_body && is_video && idx_ff == stream_desc_pkg::IDX_0) begin
			vid_mixed_ff <= in_byte[stream_desc_pkg::VID_MIXED_BIT]; // R06
			vid_rate_ff <= in_byte[stream_desc_pkg::VID_RATE_HI:stream_desc_pkg::VID_RATE_LO];
			vid_rate_admit_ff <= in_byte[stream_desc_pkg::VID_MIXED_BIT] ?
				stream_desc_pkg::RATE_MIXED[in_byte[6:3]] :
				stream_desc_pkg::RATE_SELF[in_byte[6:3]]; // R07
			legacy_video_only_ff <= in_byte[stream_desc_pkg::VID_LEGACY_BIT]; // R08
			vid_bounded_ff <= in_byte[stream_desc_pkg::VID_BOUNDED_BIT]; // R09
			vid_stills_ff <= in_byte[stream_desc_pkg::VID_STILLS_BIT]; // R10
		end
	end

	// Second group, read only when legacy only is set
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			vid_cap_class_ff <= 8'h00;
			vid_sampling_ff <= 2'h0;
			vid_rate_ext_ff <= 1'b0;
		end else if (take_body && is_video && legacy_video_only_ff) begin
			if (idx_ff == stream_desc_pkg::IDX_1) begin
				vid_cap_class_ff <= in_byte; // R11
			end else if (idx_ff == stream_desc_pkg::IDX_2) begin
				vid_sampling_ff <= in_byte[stream_desc_pkg::VID_SAMP_HI:stream_desc_pkg::VID_SAMP_LO];
				vid_rate_ext_ff <= in_byte[stream_desc_pkg::VID_EXT_BIT]; // R12
			end
		end
	end

	// ==========================================
	// Audio fields
	// ==========================================
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			aud_unindexed_ff <= 1'b0;
			audio_version_bit_ff <= 1'b0;
			aud_layer_ff <= 2'h0;
			aud_varies_ff <= 1'b0;
		end else if (take_body && is_audio && idx_ff == stream_desc_pkg::IDX_0) begin
			aud_unindexed_ff <= in_byte[stream_desc_pkg::AUD_UNIDX_BIT]; // R14
			audio_version_bit_ff <= in_byte[stream_desc_pkg::AUD_VER_BIT]; // R15
			aud_layer_ff <= in_byte[stream_desc_pkg::AUD_LAYER_HI:stream_desc_pkg::AUD_LAYER_LO]; // R13
			aud_varies_ff <= in_byte[stream_desc_pkg::AUD_VARIES_BIT]; // R16
		end
	end

	// ==========================================
	// Hierarchy fields
	// ==========================================
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			hier_kind_ff <= 4'h0;
			hier_base_ff <= 1'b0;
			hier_kind_res_ff <= 1'b0;
			hier_own_ff <= 6'h00;
			hier_prereq_ff <= 6'h00;
			hier_channel_ff <= 6'h00;
		end else if (take_body && is_hier) begin
			case (idx_ff)
				stream_desc_pkg::IDX_0: begin
					hier_kind_ff <= in_byte[stream_desc_pkg::HIER_KIND_HI:0]; // R17
					hier_base_ff <= in_byte[3:0] == stream_desc_pkg::HIER_BASE; // R18
					hier_kind_res_ff <= in_byte[3:0] == 4'h0 ||
						(in_byte[3:0] > stream_desc_pkg::HIER_DEF_LAST &&
						in_byte[3:0] != stream_desc_pkg::HIER_BASE);
				end
				stream_desc_pkg::IDX_1: hier_own_ff <= in_byte[stream_desc_pkg::HIER_IDX_HI:0];
				stream_desc_pkg::IDX_2: hier_prereq_ff <= in_byte[stream_desc_pkg::HIER_IDX_HI:0];
				stream_desc_pkg::IDX_3: hier_channel_ff <= in_byte[stream_desc_pkg::HIER_IDX_HI:0];
				default: hier_kind_ff <= hier_kind_ff;
			endcase
		end
	end

	// ==========================================
	// Descriptor completion
	// ==========================================
	// Fields of byte 0 may arrive in the closing cycle itself
	assign legacy_now = (take_body && idx_ff == stream_desc_pkg::IDX_0) ?
		in_byte[stream_desc_pkg::VID_LEGACY_BIT] : legacy_video_only_ff;
	assign bounded_now = (take_body && idx_ff == stream_desc_pkg::IDX_0) ?
		in_byte[stream_desc_pkg::VID_BOUNDED_BIT] : vid_bounded_ff;

	always_comb begin
		case (desc_class_ff)
			stream_desc_pkg::CL_VIDEO: need_cnt = legacy_now ? stream_desc_pkg::VID_NEED_EXT :
				stream_desc_pkg::VID_NEED_BASE; // R11
			stream_desc_pkg::CL_AUDIO: need_cnt = stream_desc_pkg::AUD_NEED;
			stream_desc_pkg::CL_HIER: need_cnt = stream_desc_pkg::HIER_NEED;
			default: need_cnt = 8'h00;
		endcase
	end

	// One-cycle pulses when a descriptor closes; hier_prereq_ok_ff holds until the next hierarchy descriptor closes
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			desc_done_ff <= 1'b0;
			desc_short_ff <= 1'b0;
			video_valid_ff <= 1'b0;
			audio_valid_ff <= 1'b0;
			hier_valid_ff <= 1'b0;
			bounded_err_ff <= 1'b0;
			hier_prereq_ok_ff <= 1'b0;
		end else begin
			desc_done_ff <= desc_end; // R20
			desc_short_ff <= desc_end && end_len < need_cnt;
			video_valid_ff <= desc_end && is_video && end_len >= need_cnt;
			audio_valid_ff <= desc_end && is_audio && end_len >= need_cnt;
			hier_valid_ff <= desc_end && is_hier && end_len >= need_cnt;
			bounded_err_ff <= desc_end && is_video && end_len != 8'h00 &&
				!legacy_now && !bounded_now; // R09
			if (desc_end && is_hier) begin
				hier_prereq_ok_ff <= hier_kind_ff != stream_desc_pkg::HIER_BASE; // R19
			end
		end
	end

	// ==========================================
	// Assertions
	// ==========================================
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	kind_then_len_a: assert property (take_kind |=> state_ff == ST_LEN) // R01
		else $error("kind byte not followed by length state");
	empty_body_a: assert property (take_len && in_byte == 8'h00 |=> state_ff == ST_KIND ##0
		desc_done_ff) // R02
		else $error("empty descriptor did not close");
	skip_count_a: assert property (take_len && in_byte == 8'h02 ##1 (take_body ##1 take_body)
		|=> desc_done_ff && state_ff == ST_KIND) // R20
		else $error("body not skipped by length");
	user_class_a: assert property (desc_class_ff == stream_desc_pkg::CL_USER |->
		desc_kind_ff >= stream_desc_pkg::KIND_USER_FIRST) // R03
		else $error("private class on low kind code");
	ps_perm_a: assert property (take_kind && prog_mux && in_byte == 8'h11 |=>
		!desc_allowed_ff) // R04
		else $error("kind permitted in wrong multiplex");
	rate_self_a: assert property (take_body && is_video && idx_ff == 8'h00 &&
		!in_byte[7] && in_byte[6:3] == 4'h8 |=> vid_rate_admit_ff == 8'h80) // R07
		else $error("single rate admits other rates");
	bounded_chk_a: assert property (bounded_err_ff |-> !legacy_video_only_ff &&
		!vid_bounded_ff && $past(is_video)) // R09
		else $error("bounded violation raised wrongly");
	audio_layer_a: assert property (take_body && is_audio && idx_ff == 8'h00 |=>
		aud_layer_ff == $past(in_byte[5:4]) && audio_version_bit_ff == $past(in_byte[6])) // R15
		else $error("audio header bits not passed through");
	hier_res_a: assert property (hier_kind_res_ff |-> hier_kind_ff == 4'h0 ||
		(hier_kind_ff > 4'h6 && hier_kind_ff < 4'hf)) // R18
		else $error("scalability kind wrongly reserved");
	ext_gate_a: assert property (take_body && is_video && !legacy_video_only_ff &&
		idx_ff == 8'h02 |=> $stable(vid_rate_ext_ff)) // R11
		else $error("extension read without legacy flag");

	video_seen_c: cover property (video_valid_ff && legacy_video_only_ff);
	audio_seen_c: cover property (audio_valid_ff);
	hier_seen_c: cover property (hier_valid_ff && hier_base_ff);
	skip_seen_c: cover property (desc_done_ff && desc_class_ff == stream_desc_pkg::CL_USER);

endmodule
`default_nettype wire

// ==== design/stream_desc_pkg.sv ====
package stream_desc_pkg;

	// ==========================================
	// Descriptor kind codes and classes
	// ==========================================
	localparam logic [7:0] KIND_VIDEO = 8'h02;
	localparam logic [7:0] KIND_AUDIO = 8'h03;
	localparam logic [7:0] KIND_HIER = 8'h04;
	localparam logic [7:0] KIND_STD_FIRST = 8'h05;
	localparam logic [7:0] KIND_STD_LAST = 8'h12;
	localparam logic [7:0] KIND_USER_FIRST = 8'h40;
	// Permission masks, one bit per kind code 0..31
	localparam logic [31:0] TS_ALLOWED = 32'h0007fffc;
	localparam logic [31:0] PS_ALLOWED = 32'h0005fffc;

	typedef enum logic [2:0] {
		CL_RESERVED,
		CL_VIDEO,
		CL_AUDIO,
		CL_HIER,
		CL_STANDARD,
		CL_USER
	} kind_class_t;

	// ==========================================
	// Video descriptor field layout
	// ==========================================
	localparam int VID_MIXED_BIT = 7;
	localparam int VID_RATE_HI = 6;
	localparam int VID_RATE_LO = 3;
	localparam int VID_LEGACY_BIT = 2;
	localparam int VID_BOUNDED_BIT = 1;
	localparam int VID_STILLS_BIT = 0;
	localparam int VID_SAMP_HI = 7;
	localparam int VID_SAMP_LO = 6;
	localparam int VID_EXT_BIT = 5;
	localparam logic [7:0] VID_NEED_BASE = 8'h01;
	localparam logic [7:0] VID_NEED_EXT = 8'h03;

	// Admitted rates per picture rate index, bit n means rate index n+1
	localparam logic [7:0] RATE_MIXED [0:15] = '{8'h00, 8'h01, 8'h03, 8'h04, 8'h09, 8'h1b,
		8'h24, 8'h49, 8'hdb, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
	localparam logic [7:0] RATE_SELF [0:15] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h08, 8'h10,
		8'h20, 8'h40, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

	// ==========================================
	// Audio and hierarchy field layout
	// ==========================================
	localparam int AUD_UNIDX_BIT = 7;
	localparam int AUD_VER_BIT = 6;
	localparam int AUD_LAYER_HI = 5;
	localparam int AUD_LAYER_LO = 4;
	localparam int AUD_VARIES_BIT = 3;
	localparam logic [7:0] AUD_NEED = 8'h01;
	localparam int HIER_KIND_HI = 3;
	localparam int HIER_IDX_HI = 5;
	localparam logic [7:0] HIER_NEED = 8'h04;
	localparam logic [3:0] HIER_BASE = 4'hf;
	localparam logic [3:0] HIER_DEF_LAST = 4'h6;

	// Body byte positions
	localparam logic [7:0] IDX_0 = 8'h00;
	localparam logic [7:0] IDX_1 = 8'h01;
	localparam logic [7:0] IDX_2 = 8'h02;
	localparam logic [7:0] IDX_3 = 8'h03;

endpackage

// ==== design/desc_kind_decode.sv ====
`timescale 1ns/1ns
`default_nettype none

module desc_kind_decode (
	// Kind code and context
	input wire logic [7:0] kind,
	input wire logic prog_mux,
	// Decoded class
	output var stream_desc_pkg::kind_class_t kind_class,
	output logic allowed
);

	// ==========================================
	// Kind code classification
	// ==========================================
	always_comb begin
		if (kind >= stream_desc_pkg::KIND_USER_FIRST) begin
			kind_class = stream_desc_pkg::CL_USER;
		end else if (kind == stream_desc_pkg::KIND_VIDEO) begin
			kind_class = stream_desc_pkg::CL_VIDEO;
		end else if (kind == stream_desc_pkg::KIND_AUDIO) begin
			kind_class = stream_desc_pkg::CL_AUDIO;
		end else if (kind == stream_desc_pkg::KIND_HIER) begin
			kind_class = stream_desc_pkg::CL_HIER;
		end else if (kind >= stream_desc_pkg::KIND_STD_FIRST &&
			kind <= stream_desc_pkg::KIND_STD_LAST) begin
			kind_class = stream_desc_pkg::CL_STANDARD;
		end else begin
			kind_class = stream_desc_pkg::CL_RESERVED; // R03
		end
	end

	// Permission in the multiplex type in use
	always_comb begin
		if (kind[7:5] != 3'h0) begin
			allowed = 1'b0;
		end else if (prog_mux) begin
			allowed = stream_desc_pkg::PS_ALLOWED[kind[4:0]]; // R04
		end else begin
			allowed = stream_desc_pkg::TS_ALLOWED[kind[4:0]]; // R05
		end
	end

endmodule
`default_nettype wire

// ==== bench/desc_byte_source.sv ====
`timescale 1ns/1ns
`default_nettype none

// ==========================================
// Upstream table-section byte source
// ==========================================
module desc_byte_source (
	// Clock
	input wire logic ref_clk,
	// Byte stream toward the parser
	output logic in_valid,
	output logic [7:0] in_byte,
	output logic in_sync
);

	// Quiet line at time zero
	initial begin
		in_valid = 1'b0;
		in_byte = 8'h00;
		in_sync = 1'b0;
	end

	// Release the line; stale data is inverted so it never looks like a fresh byte
	task automatic idle(input int n);
		in_valid = 1'b0;
		in_byte = ~in_byte;
		repeat (n) begin
			@(posedge ref_clk);
			#1;
		end
	endtask

	// Offer one byte just after an edge and hold it until the edge that takes it
	task automatic put(input logic [7:0] b);
		in_valid = 1'b1;
		in_byte = b;
		@(posedge ref_clk);
		#1;
	endtask

	// Whole stream of descriptors, gap idle cycles before each byte (slow source)
	// The last byte stays offered: the caller replaces it or releases the line before an edge
	task automatic send(input logic [7:0] bytes[$], input int gap);
		foreach (bytes[i]) begin
			if (gap > 0) begin
				idle(gap);
			end
			put(bytes[i]);
		end
	endtask

	// Realignment strobe; the byte offered with it must be ignored
	task automatic resync();
		in_sync = 1'b1;
		in_valid = 1'b1;
		in_byte = 8'h03;
		@(posedge ref_clk);
		#1;
		in_sync = 1'b0;
		idle(1);
	endtask

endmodule

`default_nettype wire

// ==== bench/stream_descriptor_parser_test.sv ====
`timescale 1ns/1ns
`default_nettype none

// ==========================================
// Descriptor parser testbench
// ==========================================
module stream_descriptor_parser_test;

	logic ref_clk, rst_n, in_valid, in_sync, prog_mux;
	logic [7:0] in_byte, desc_kind_ff, vid_rate_admit_ff, vid_cap_class_ff;
	stream_desc_pkg::kind_class_t desc_class_ff;
	logic desc_done_ff, desc_allowed_ff, desc_short_ff, video_valid_ff, vid_mixed_ff;
	logic legacy_video_only_ff, vid_bounded_ff, vid_stills_ff, vid_rate_ext_ff, bounded_err_ff;
	logic [3:0] vid_rate_ff, hier_kind_ff;
	logic [1:0] vid_sampling_ff, aud_layer_ff;
	logic audio_valid_ff, aud_unindexed_ff, audio_version_bit_ff, aud_varies_ff;
	logic hier_valid_ff, hier_base_ff, hier_kind_res_ff, hier_prereq_ok_ff;
	logic [5:0] hier_own_ff, hier_prereq_ff, hier_channel_ff;
	int err_total = 0;
	int checked = 0;
	int cycles = 0;
	logic [7:0] q[$];
	logic [7:0] mixed_tab [8] = '{8'h01, 8'h03, 8'h04, 8'h09, 8'h1b, 8'h24, 8'h49, 8'hdb};
	int hk [5] = '{0, 6, 7, 14, 15};
	int kinds [9] = '{0, 1, 5, 17, 18, 19, 63, 64, 255};

	// Parser and its upstream source
	stream_descriptor_parser dut_u (.ref_clk, .rst_n, .in_valid, .in_byte, .in_sync, .prog_mux,
		.desc_done_ff, .desc_kind_ff, .desc_class_ff, .desc_allowed_ff, .desc_short_ff,
		.video_valid_ff, .vid_mixed_ff, .vid_rate_ff, .vid_rate_admit_ff, .legacy_video_only_ff,
		.vid_bounded_ff, .vid_stills_ff, .vid_cap_class_ff, .vid_sampling_ff, .vid_rate_ext_ff,
		.bounded_err_ff, .audio_valid_ff, .aud_unindexed_ff, .audio_version_bit_ff,
		.aud_layer_ff, .aud_varies_ff, .hier_valid_ff, .hier_kind_ff, .hier_base_ff,
		.hier_kind_res_ff, .hier_own_ff, .hier_prereq_ff, .hier_prereq_ok_ff, .hier_channel_ff);
	desc_byte_source src_u (.ref_clk(ref_clk), .in_valid(in_valid), .in_byte(in_byte),
		.in_sync(in_sync));

	// 10 MHz clock
	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end

	// Compare and count
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch at %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask

	// Verdict and end of run
	task automatic finish_test();
		if (err_total == 0 && checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// Expected class of a skipped kind code
	function automatic logic [7:0] cls(input int k);
		if (k < 2 || (k >= 19 && k < 64)) return 8'(stream_desc_pkg::CL_RESERVED);
		if (k >= 64) return 8'(stream_desc_pkg::CL_USER);
		return 8'(stream_desc_pkg::CL_STANDARD);
	endfunction

	// Cut a hung run short
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 20000) begin
			err_total++;
			finish_test();
		end
	end

	// Main sequence
	initial begin
		rst_n = 1'b0;
		prog_mux = 1'b0;
		repeat (16) @(posedge ref_clk);
		#1;
		rst_n = 1'b1;
		@(posedge ref_clk);
		#1;
		chk(desc_done_ff, 8'h00);
		chk(desc_class_ff, stream_desc_pkg::CL_RESERVED);
		chk(vid_rate_admit_ff, 8'h00);
		// Rate indices 1 to 8, single and mixed rates
		for (int m = 0; m < 2; m++) begin
			for (int r = 1; r <= 8; r++) begin
				q = '{stream_desc_pkg::KIND_VIDEO, 8'h01, {m[0], r[3:0], 1'b0, 1'b1, r[0]}};
				src_u.send(q, 0);
				chk(video_valid_ff, 8'h01);
				chk(vid_mixed_ff, m[0]);
				chk(vid_rate_ff, r[3:0]);
				chk(vid_rate_admit_ff, m ? mixed_tab[r - 1] : 8'(1 << (r - 1)));
				chk(legacy_video_only_ff, 8'h00);
				chk(vid_bounded_ff, 8'h01);
				chk(vid_stills_ff, r[0]);
				chk(bounded_err_ff, 8'h00);
				chk(desc_allowed_ff, 8'h01);
			end
		end
		// Legacy group, excess byte skipped, audio back to back
		q = '{8'h02, 8'h04, 8'h14, 8'h5a, 8'ha0, 8'h77, 8'h03, 8'h01, 8'ha8};
		src_u.send(q, 0);
		chk(vid_cap_class_ff, 8'h5a);
		chk(vid_sampling_ff, 8'h02);
		chk(vid_rate_ext_ff, 8'h01);
		chk(legacy_video_only_ff, 8'h01);
		chk(audio_valid_ff, 8'h01);
		chk(aud_unindexed_ff, 8'h01);
		chk(audio_version_bit_ff, 8'h00);
		chk(aud_layer_ff, 8'h02);
		chk(aud_varies_ff, 8'h01);
		// Slow source, other audio values
		q = '{8'h03, 8'h01, 8'h50};
		src_u.send(q, 3);
		chk(aud_unindexed_ff, 8'h00);
		chk(audio_version_bit_ff, 8'h01);
		chk(aud_layer_ff, 8'h01);
		chk(aud_varies_ff, 8'h00);
		// Bounded flag clear without legacy video; second group must not load
		q = '{8'h02, 8'h03, 8'h08, 8'h11, 8'h00};
		src_u.send(q, 0);
		chk(bounded_err_ff, 8'h01);
		chk(vid_cap_class_ff, 8'h5a);
		chk(vid_rate_ext_ff, 8'h01);
		// Legacy set but second group missing
		q = '{8'h02, 8'h01, 8'h04};
		src_u.send(q, 0);
		chk(desc_short_ff, 8'h01);
		chk(video_valid_ff, 8'h00);
		// Scalability kinds including base layer and reserved ones
		foreach (hk[i]) begin
			q = '{8'h04, 8'h04, {4'hf, hk[i][3:0]}, 8'hc5, 8'hea, 8'h3f};
			src_u.send(q, 0);
			chk(hier_valid_ff, 8'h01);
			chk(desc_class_ff, stream_desc_pkg::CL_HIER);
			chk(hier_kind_ff, hk[i][3:0]);
			chk(hier_own_ff, 8'h05);
			chk(hier_prereq_ff, 8'h2a);
			chk(hier_channel_ff, 8'h3f);
			chk(hier_base_ff, 8'(hk[i] == 15));
			chk(hier_kind_res_ff, 8'(hk[i] == 0 || (hk[i] >= 7 && hk[i] <= 14)));
			chk(hier_prereq_ok_ff, 8'(hk[i] != 15));
		end
		// Unparsed kinds in both multiplex types; body bytes look like kind codes
		for (int pm = 0; pm < 2; pm++) begin
			prog_mux = pm[0];
			foreach (kinds[i]) begin
				q = '{kinds[i][7:0], 8'h02, 8'h03, 8'h02};
				src_u.send(q, 0);
				chk(desc_done_ff, 8'h01);
				chk(desc_kind_ff, kinds[i][7:0]);
				chk(desc_class_ff, cls(kinds[i]));
				chk(desc_allowed_ff, 8'(kinds[i] >= 2 && kinds[i] <= 18 && !(pm == 1 && kinds[i] == 17)));
			end
		end
		// Empty body closes at once, pulse lasts one cycle
		q = '{8'h40, 8'h00};
		src_u.send(q, 0);
		chk(desc_done_ff, 8'h01);
		src_u.idle(0);
		@(posedge ref_clk);
		#1;
		chk(desc_done_ff, 8'h00);
		// Realign in mid-body, then a fresh audio descriptor
		q = '{8'h02, 8'h03, 8'h00};
		src_u.send(q, 0);
		src_u.resync();
		q = '{8'h03, 8'h01, 8'hf8};
		src_u.send(q, 0);
		chk(audio_valid_ff, 8'h01);
		chk(aud_layer_ff, 8'h03);
		finish_test();
	end

endmodule

`default_nettype wire
